// *** core/sdcbc_pkg.sv ***
/*
 Package for the command and bank control block of a four-bank synchronous DRAM.
 Holds command encodings, mode field positions, widths and the carrier structs.
 Assumes every user compiles it first and imports it whole.
*/
package sdcbc_pkg;

	// Widths of the memory interface.
	localparam int SDCBC_ROW_W = 12;
	localparam int SDCBC_COL_W = 9;
	localparam int SDCBC_BANK_W = 2;
	localparam int SDCBC_BANKS = 4;
	localparam int SDCBC_DATA_W = 32;
	localparam int SDCBC_MASK_W = 4;

	// Auto precharge and close-all flag sits on address bit ten.
	localparam int SDCBC_AUTO_PRE_BIT = 10;

	// Mode word field positions, taken from the low address bits.
	localparam int SDCBC_MODE_BL_LSB = 0;
	localparam int SDCBC_MODE_BT_BIT = 3;
	localparam int SDCBC_MODE_CL_LSB = 4;

	// Burst length codes in the mode word.
	localparam logic [2:0] SDCBC_BL_1 = 3'h0;
	localparam logic [2:0] SDCBC_BL_2 = 3'h1;
	localparam logic [2:0] SDCBC_BL_4 = 3'h2;
	localparam logic [2:0] SDCBC_BL_8 = 3'h3;
	localparam logic [2:0] SDCBC_BL_PAGE = 3'h7;

	// Reset value of the mode word: burst of one, sequential, latency two.
	localparam logic [13:0] SDCBC_MODE_RESET = 14'h0020;

	// Read mask latency in clock cycles.
	localparam int SDCBC_MASK_LAT = 2;

	// Largest column latency that the pipeline supports.
	localparam int SDCBC_MAX_CL = 3;

	// Strobe pattern order: cs_n, ras_n, cas_n, we_n.
	localparam logic [3:0] SDCBC_CMD_ACT = 4'h3;
	localparam logic [3:0] SDCBC_CMD_PRE = 4'h2;
	localparam logic [3:0] SDCBC_CMD_WR = 4'h4;
	localparam logic [3:0] SDCBC_CMD_RD = 4'h5;
	localparam logic [3:0] SDCBC_CMD_MODE = 4'h0;
	localparam logic [3:0] SDCBC_CMD_REF = 4'h1;
	localparam logic [3:0] SDCBC_CMD_NOP = 4'h7;
	localparam logic [3:0] SDCBC_CMD_STOP = 4'h6;

	// Device power state.
	typedef enum logic [1:0] {
		SDCBC_PW_RUN,
		SDCBC_PW_SUSPEND,
		SDCBC_PW_DOWN,
		SDCBC_PW_SELF_REF
	} sdcbc_power_t;

	// One command as sampled at the pins.
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [SDCBC_BANK_W-1:0] bank_sel;
		logic [SDCBC_ROW_W-1:0] addr;
	} sdcbc_cmd_t;

	// One read word heading for the pins, with its byte enables.
	typedef struct packed {
		logic [SDCBC_DATA_W-1:0] data;
		logic [SDCBC_MASK_W-1:0] byte_on;
	} sdcbc_word_t;

	// One write request towards the array.
	typedef struct packed {
		logic [SDCBC_BANK_W-1:0] bank;
		logic [SDCBC_ROW_W-1:0] row;
		logic [SDCBC_COL_W-1:0] col;
		logic [SDCBC_DATA_W-1:0] data;
		logic [SDCBC_MASK_W-1:0] byte_en;
	} sdcbc_write_t;

endpackage

// *** core/sdcbc_skid.sv ***
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes a single clock and an active-high asynchronous reset.
*/
module sdcbc_skid
	import sdcbc_pkg::*;
#(
	parameter int WIDTH = 32
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	// Two storage slots; slot zero is always the head.
	logic [WIDTH-1:0] slot [2];
	// Number of words held, zero to two.
	logic [1:0] count;

	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// Full only when both slots hold a word, so the filler sees real back-pressure.
	assign in_ready = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data = slot[0];

	// Occupancy count follows pushes and pops.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			count <= 2'h0;
		end else begin
			count <= count + 2'(push) - 2'(pop);
		end
	end

	// Data moves forward on a pop; a push lands in the first free slot.
	always_ff @(posedge clock) begin
		if (pop) begin
			slot[0] <= slot[1];
		end
		if (push) begin
			if (count == 2'h0 || (count == 2'h1 && pop)) begin
				slot[0] <= in_data;
			end else begin
				slot[(count == 2'h2) ? 0 : (pop ? 0 : 1)] <= in_data;
			end
		end
	end

endmodule

// *** core/sdcbc_core.sv ***
/*
 Command decoding, per-bank row state and read burst sequencing of a four-bank
 synchronous DRAM. Reads come from an array port outside the block with one cycle
 of latency; writes leave through a two-entry buffer towards that array.
 Assumes the controller drives all pins from the same clock; pins still pass a
 three-stage sampler because they cross from outside the chip.
*/
module sdcbc_core
	import sdcbc_pkg::*;
#(
	parameter int COL_W = SDCBC_COL_W
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_gate,
	input wire sdcbc_cmd_t cmd_pins,
	input wire logic [SDCBC_MASK_W-1:0] byte_mask,
	input wire logic [SDCBC_DATA_W-1:0] data_pins_in,
	output logic [SDCBC_DATA_W-1:0] data_pins_out,
	output logic [SDCBC_MASK_W-1:0] data_pins_oe_n,
	output logic [SDCBC_BANK_W-1:0] array_rd_bank,
	output logic [SDCBC_ROW_W-1:0] array_rd_row,
	output logic [COL_W-1:0] array_rd_col,
	input wire logic [SDCBC_DATA_W-1:0] array_rd_data,
	output logic array_wr_valid,
	input wire logic array_wr_ready,
	output sdcbc_write_t array_wr,
	output logic wr_stall,
	output logic [SDCBC_BANKS-1:0] bank_open,
	output sdcbc_power_t power_state,
	output logic refresh_pulse,
	output logic [13:0] mode_word
);

	// Three-stage pin sampler; stage one feeds only stage two.
	localparam int PIN_W = $bits(sdcbc_cmd_t) + SDCBC_MASK_W + SDCBC_DATA_W + 1;
	// Reset shows the idle pins (gate high, deselect), so no false gate edge or command follows reset.
	localparam logic [PIN_W-1:0] PIN_IDLE = {5'h1F, (PIN_W - 5)'(0)};
	logic [PIN_W-1:0] pin_s1, pin_s2, pin_s3;

	// Sampled pins, taken at rising edges only.
	// edge sampling only
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pin_s1 <= PIN_IDLE;
			pin_s2 <= PIN_IDLE;
			pin_s3 <= PIN_IDLE;
		end else begin
			pin_s1 <= {clk_gate, cmd_pins, byte_mask, data_pins_in};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	// A sample counts once stages two and three agree; a change still settling is held off.
	// Data pins are left out: they change on every beat of a write burst and must not hold commands off.
	wire pins_settled = (pin_s2[PIN_W-1:SDCBC_DATA_W] == pin_s3[PIN_W-1:SDCBC_DATA_W]);
	sdcbc_cmd_t cmd;
	logic gate_now;
	logic [SDCBC_MASK_W-1:0] mask_now;
	logic [SDCBC_DATA_W-1:0] wdata_now;
	assign {gate_now, cmd, mask_now, wdata_now} = pin_s3;

	// Clock enable one cycle before the command edge.
	logic clk_gate_prev_level;

	// Per-bank open flag and latched row.
	logic [SDCBC_ROW_W-1:0] open_row [SDCBC_BANKS];

	// Burst sequencer state.
	logic burst_on;
	logic burst_write;
	logic burst_auto_pre;
	logic [SDCBC_BANK_W-1:0] burst_bank;
	logic [COL_W-1:0] burst_start;
	logic [COL_W-1:0] burst_cnt;
	logic [COL_W-1:0] burst_left;

	// Read pipeline towards the pins, indexed by cycles since the array read.
	logic [SDCBC_MAX_CL:0] rd_pipe_v;
	logic [SDCBC_MASK_W-1:0] mask_d1, mask_d2;
	// Array word held one more cycle for the longer column latency.
	logic [SDCBC_DATA_W-1:0] rd_data_d1;

	// Decoded mode settings.
	wire [2:0] mode_bl = mode_word[SDCBC_MODE_BL_LSB +: 3];
	wire mode_interleave = mode_word[SDCBC_MODE_BT_BIT];
	wire [2:0] mode_cl = mode_word[SDCBC_MODE_CL_LSB +: 3];

	// Burst length in words; full page uses the whole column space.
	function automatic logic [COL_W-1:0] burst_words(input logic [2:0] code);
		unique case (code)
			SDCBC_BL_1: burst_words = COL_W'(1);
			SDCBC_BL_2: burst_words = COL_W'(2);
			SDCBC_BL_4: burst_words = COL_W'(4);
			SDCBC_BL_8: burst_words = COL_W'(8);
			default: burst_words = '0;
		endcase
	endfunction

	// Column of step n: sequential adds within the burst, interleave xors; full page wraps.
	function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start, input logic [COL_W-1:0] n,
		input logic [2:0] code, input logic ilv);
		logic [COL_W-1:0] span;
		span = burst_words(code) - COL_W'(1);
		if (code == SDCBC_BL_PAGE) begin
			burst_col = start + n;
		end else if (ilv) begin
			burst_col = (start & ~span) | ((start ^ n) & span);
		end else begin
			burst_col = (start & ~span) | ((start + n) & span);
		end
	endfunction

	// Command decode, valid only with a settled sample, chip select low, gate high before.
	// gate pair selects transition
	wire cmd_edge = pins_settled && clk_gate_prev_level;
	wire run_edge = cmd_edge && gate_now;
	wire [3:0] strobes = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n};
	wire sel = !cmd.cs_n;
	wire all_idle = (bank_open == '0);
	wire tgt_open = bank_open[cmd.bank_sel];
	wire in_run = (power_state == SDCBC_PW_RUN);
	wire do_act = run_edge && in_run && sel && strobes[2:0] == SDCBC_CMD_ACT[2:0] && !tgt_open;
	wire do_pre = run_edge && in_run && sel && strobes[2:0] == SDCBC_CMD_PRE[2:0];
	wire do_col = run_edge && in_run && sel && strobes[2:1] == SDCBC_CMD_WR[2:1] && tgt_open;
	wire do_mode = run_edge && in_run && sel && strobes[2:0] == SDCBC_CMD_MODE[2:0] && all_idle;
	// refresh only with every bank idle
	wire is_ref = sel && strobes[2:0] == SDCBC_CMD_REF[2:0] && all_idle && in_run;
	wire do_ref = run_edge && is_ref;
	wire do_self = cmd_edge && !gate_now && is_ref;
	wire do_stop = run_edge && in_run && sel && strobes[2:0] == SDCBC_CMD_STOP[2:0];
	wire pre_all = cmd.addr[SDCBC_AUTO_PRE_BIT];

	// Burst step happens only while the internal clock runs.
	wire gate_low_edge = pins_settled && clk_gate_prev_level && !gate_now;
	wire burst_step = burst_on && in_run && !gate_low_edge && !wr_stall;
	wire burst_last = burst_step && burst_left == COL_W'(1) && mode_bl != SDCBC_BL_PAGE;
	wire [COL_W-1:0] cur_col = burst_col(burst_start, burst_cnt, mode_bl, mode_interleave);

	// Write path: word goes to the buffer when the byte is unmasked somewhere.
	logic wr_in_ready;
	sdcbc_write_t wr_req;
	wire wr_push = burst_step && burst_write && (mask_now != '1);
	assign wr_req = '{bank: burst_bank, row: open_row[burst_bank], col: cur_col, data: wdata_now,
		byte_en: ~mask_now};
	// A full buffer stops the burst counter rather than lose a word.
	assign wr_stall = burst_on && burst_write && !wr_in_ready;

	sdcbc_skid #(
		.WIDTH($bits(sdcbc_write_t))
	) u_wr_buf (
		.clock(clock),
		.sys_rst(sys_rst),
		.in_valid(wr_push),
		.in_ready(wr_in_ready),
		.in_data(wr_req),
		.out_valid(array_wr_valid),
		.out_ready(array_wr_ready),
		.out_data(array_wr)
	);

	// Array read address for the current burst step.
	assign array_rd_bank = burst_bank;
	assign array_rd_row = open_row[burst_bank];
	assign array_rd_col = cur_col;

	// Clock enable history and power state.
	// power transitions
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			clk_gate_prev_level <= 1'b1;
			power_state <= SDCBC_PW_RUN;
		end else if (pins_settled) begin
			clk_gate_prev_level <= gate_now;
			unique case (power_state)
				SDCBC_PW_RUN: begin
					if (do_self) begin
						power_state <= SDCBC_PW_SELF_REF;
					end else if (gate_low_edge) begin
						power_state <= burst_on ? SDCBC_PW_SUSPEND : SDCBC_PW_DOWN;
					end
				end
				SDCBC_PW_SUSPEND, SDCBC_PW_DOWN: begin
					if (gate_now) begin
						power_state <= SDCBC_PW_RUN;
					end
				end
				SDCBC_PW_SELF_REF: begin
					// Exit needs deselect or a no-op with the gate back high.
					if (gate_now && (cmd.cs_n || strobes[2:0] == SDCBC_CMD_NOP[2:0])) begin
						power_state <= SDCBC_PW_RUN;
					end
				end
			endcase
		end
	end

	// Bank open flags and rows.
	// bank state updates
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			bank_open <= '0;
		end else begin
			for (int b = 0; b < SDCBC_BANKS; b++) begin
				if (do_act && cmd.bank_sel == b[SDCBC_BANK_W-1:0]) begin
					bank_open[b] <= 1'b1;
				end else if (do_pre && (pre_all || cmd.bank_sel == b[SDCBC_BANK_W-1:0])) begin
					bank_open[b] <= 1'b0;
				end else if (burst_on && burst_auto_pre && burst_bank == b[SDCBC_BANK_W-1:0]
					&& (burst_last || do_stop)) begin
					bank_open[b] <= 1'b0;
				end
			end
		end
	end

	// Row latch on activate.
	always_ff @(posedge clock) begin
		if (do_act) begin
			open_row[cmd.bank_sel] <= cmd.addr;
		end
	end

	// Mode word loads from bank bits and address together.
	// mode word load
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			mode_word <= SDCBC_MODE_RESET;
		end else if (do_mode) begin
			mode_word <= {cmd.bank_sel, cmd.addr};
		end
	end

	// Refresh pulse, one cycle per accepted auto refresh.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			refresh_pulse <= 1'b0;
		end else begin
			refresh_pulse <= do_ref;
		end
	end

	// Burst sequencer; a new column command overrides a running burst.
	// burst control
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			burst_on <= 1'b0;
			burst_write <= 1'b0;
			burst_auto_pre <= 1'b0;
			burst_bank <= '0;
			burst_start <= '0;
			burst_cnt <= '0;
			burst_left <= '0;
		end else if (do_col) begin
			burst_on <= 1'b1;
			burst_write <= !cmd.we_n;
			burst_auto_pre <= cmd.addr[SDCBC_AUTO_PRE_BIT];
			burst_bank <= cmd.bank_sel;
			burst_start <= cmd.addr[COL_W-1:0];
			burst_cnt <= '0;
			burst_left <= burst_words(mode_bl);
		end else if (do_stop || burst_last) begin
			burst_on <= 1'b0;
		end else if (burst_step) begin
			burst_cnt <= burst_cnt + COL_W'(1);
			burst_left <= burst_left - COL_W'(1);
		end
	end

	// Write data of the command cycle itself is not taken; the first burst step takes the word one cycle later.
	// Read pipeline: array answers one cycle after the step; latency counts from the command.
	// latency pipeline
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rd_pipe_v <= '0;
			mask_d1 <= '1;
			mask_d2 <= '1;
			rd_data_d1 <= '0;
		end else if (power_state != SDCBC_PW_SUSPEND) begin
			rd_pipe_v <= {rd_pipe_v[SDCBC_MAX_CL-1:0], burst_step && !burst_write};
			mask_d1 <= mask_now;
			mask_d2 <= mask_d1;
			rd_data_d1 <= array_rd_data;
		end
	end

	// Output word and per-byte enables, both from flip-flops.
	// release and read masking
	// The array answers one cycle after the step, so latency two uses stage zero and latency three stage one.
	wire rd_out_v = rd_pipe_v[mode_cl[1:0] - 2'h2];
	wire [SDCBC_DATA_W-1:0] rd_word = (mode_cl == 3'(SDCBC_MAX_CL)) ? rd_data_d1 : array_rd_data;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			data_pins_out <= '0;
			data_pins_oe_n <= '1;
		end else if (power_state != SDCBC_PW_SUSPEND) begin
			data_pins_out <= rd_word;
			data_pins_oe_n <= rd_out_v ? mask_d2 : '1;
		end
	end

endmodule

// *** verification/sdcbc_core_chk.sv ***
/*
 Checker for the command and bank control block, bound to its top module.
 Assumes one clock and the active-high asynchronous reset of the block.
*/
module sdcbc_core_chk
	import sdcbc_pkg::*;
#(
	parameter int COL_W = SDCBC_COL_W
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_gate,
	input wire sdcbc_cmd_t cmd_pins,
	input wire logic [SDCBC_MASK_W-1:0] byte_mask,
	input wire logic [SDCBC_DATA_W-1:0] data_pins_in,
	input wire logic [SDCBC_DATA_W-1:0] data_pins_out,
	input wire logic [SDCBC_MASK_W-1:0] data_pins_oe_n,
	input wire logic [SDCBC_BANK_W-1:0] array_rd_bank,
	input wire logic [SDCBC_ROW_W-1:0] array_rd_row,
	input wire logic [COL_W-1:0] array_rd_col,
	input wire logic [SDCBC_DATA_W-1:0] array_rd_data,
	input wire logic array_wr_valid,
	input wire logic array_wr_ready,
	input wire sdcbc_write_t array_wr,
	input wire logic wr_stall,
	input wire logic [SDCBC_BANKS-1:0] bank_open,
	input wire sdcbc_power_t power_state,
	input wire logic refresh_pulse,
	input wire logic [13:0] mode_word
);
	timeunit 1ns;
	timeprecision 1ps;

	// All checks share the one clock and are quiet during reset.
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	reset_state_a: assert property ($fell(sys_rst) |-> mode_word == SDCBC_MODE_RESET && bank_open == 4'h0)
		else $error("state after reset is wrong");
	refresh_once_a: assert property (refresh_pulse |=> !refresh_pulse)
		else $error("refresh pulse lasts too long");
	refresh_idle_a: assert property (refresh_pulse |-> bank_open == 4'h0)
		else $error("refresh with a bank open");
	mode_idle_a: assert property ($changed(mode_word) |-> $past(bank_open) == 4'h0)
		else $error("mode word changed with a bank open");
	one_open_a: assert property ($countones(bank_open & ~$past(bank_open)) <= 1)
		else $error("more than one bank opened at once");
	stall_full_a: assert property (wr_stall |-> array_wr_valid)
		else $error("stall without a waiting word");
	wr_hold_a: assert property (array_wr_valid && !array_wr_ready |=> array_wr_valid && $stable(array_wr))
		else $error("waiting write word changed or dropped");
	suspend_freeze_a: assert property (power_state == SDCBC_PW_SUSPEND && $past(power_state) == SDCBC_PW_SUSPEND
		|-> $stable(data_pins_out) && $stable(data_pins_oe_n)) else $error("outputs moved in suspend");
	selfref_idle_a: assert property (power_state == SDCBC_PW_SELF_REF |-> bank_open == 4'h0 && &data_pins_oe_n)
		else $error("self refresh with bank open or pins driven");

	// Main scenarios that the bench is expected to reach.
	cover property (wr_stall);
	cover property (power_state == SDCBC_PW_SUSPEND);
	cover property (refresh_pulse);
	cover property (power_state == SDCBC_PW_SELF_REF);
endmodule

bind sdcbc_core sdcbc_core_chk #(.COL_W(COL_W)) sdcbc_core_chk_i (.clock(clock), .sys_rst(sys_rst),
	.clk_gate(clk_gate), .cmd_pins(cmd_pins), .byte_mask(byte_mask), .data_pins_in(data_pins_in),
	.data_pins_out(data_pins_out), .data_pins_oe_n(data_pins_oe_n), .array_rd_bank(array_rd_bank),
	.array_rd_row(array_rd_row), .array_rd_col(array_rd_col), .array_rd_data(array_rd_data),
	.array_wr_valid(array_wr_valid), .array_wr_ready(array_wr_ready), .array_wr(array_wr),
	.wr_stall(wr_stall), .bank_open(bank_open), .power_state(power_state),
	.refresh_pulse(refresh_pulse), .mode_word(mode_word));

// *** verification/sdcbc_ctl_model.sv ***
/*
 Model of the external controller that drives commands, gate, masks and write data.
 Assumes the block's clock; every pin changes just after a rising edge.
*/
module sdcbc_ctl_model
	import sdcbc_pkg::*;
#(
	parameter int GAP = 4
) (
	input wire logic clock,
	output logic clk_gate,
	output sdcbc_cmd_t cmd_pins,
	output logic [SDCBC_MASK_W-1:0] byte_mask,
	output logic [SDCBC_DATA_W-1:0] data_pins_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// Write data is held only while a write burst is meant to run.
	logic hold = 1'b0;
	logic [SDCBC_DATA_W-1:0] wdata = 32'h0;

	initial begin
		clk_gate = 1'b1;
		cmd_pins = {SDCBC_CMD_NOP, 2'h0, 12'h000};
		byte_mask = 4'h0;
		data_pins_in = 32'h0F0F0F0F;
	end

	// Released data lines toggle, so a stale word can never pass as written data.
	always @(posedge clock) begin
		data_pins_in <= hold ? wdata : ~data_pins_in;
	end

	// Sets gate, mask and write data together at one edge.
	task automatic io(input logic g, input logic [3:0] m, input logic [31:0] d, input logic h);
		@(posedge clock);
		clk_gate <= g;
		byte_mask <= m;
		wdata <= d;
		hold <= h;
	endtask

	// command spacing kept
	// Each command stands two cycles, then a no-operation with a changed address and a gap.
	task automatic send(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
		@(posedge clock);
		cmd_pins <= {c, b, a};
		repeat (2) @(posedge clock);
		cmd_pins <= {SDCBC_CMD_NOP, b, ~a};
		repeat (GAP) @(posedge clock);
	endtask

	// Gate and strobes change at one edge: gate low with refresh enters self refresh, gate high with a no-op leaves.
	task automatic self_ref(input logic g);
		@(posedge clock);
		clk_gate <= g;
		cmd_pins <= {(g ? SDCBC_CMD_NOP : SDCBC_CMD_REF), 2'h0, 12'h000};
		repeat (GAP + 2) @(posedge clock);
	endtask
endmodule

// *** verification/tb_sdram_command_bank_control.sv ***
/*
 Self-checking bench for the command and bank control block.
 Assumes the controller model drives the pins and a simple array answers reads.
*/
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
	$display("FAIL %s expected %h seen %h", what, exp, got); end end
module tb_sdram_command_bank_control
	import sdcbc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0, sys_rst = 1'b1, array_wr_ready = 1'b1, clk_gate;
	sdcbc_cmd_t cmd_pins;
	logic [3:0] byte_mask, data_pins_oe_n, bank_open;
	logic [31:0] data_pins_in, data_pins_out, array_rd_data = 32'h0;
	logic [1:0] array_rd_bank;
	logic [11:0] array_rd_row;
	logic [8:0] array_rd_col;
	logic array_wr_valid, wr_stall, refresh_pulse;
	sdcbc_write_t array_wr;
	sdcbc_power_t power_state;
	logic [13:0] mode_word;
	int n_errors = 0, comparisons = 0, nref = 0, n;
	// Captured read words and accepted write words.
	logic [31:0] rq[$];
	sdcbc_write_t wq[$];

	sdcbc_core sdcbc_core_i (.clock(clock), .sys_rst(sys_rst), .clk_gate(clk_gate), .cmd_pins(cmd_pins),
		.byte_mask(byte_mask), .data_pins_in(data_pins_in), .data_pins_out(data_pins_out),
		.data_pins_oe_n(data_pins_oe_n), .array_rd_bank(array_rd_bank), .array_rd_row(array_rd_row),
		.array_rd_col(array_rd_col), .array_rd_data(array_rd_data), .array_wr_valid(array_wr_valid),
		.array_wr_ready(array_wr_ready), .array_wr(array_wr), .wr_stall(wr_stall), .bank_open(bank_open),
		.power_state(power_state), .refresh_pulse(refresh_pulse), .mode_word(mode_word));
	sdcbc_ctl_model ctl (.clock(clock), .clk_gate(clk_gate), .cmd_pins(cmd_pins), .byte_mask(byte_mask),
		.data_pins_in(data_pins_in));

	always #5 clock = ~clock;

	// Array contents encode their own address, so every word names where it came from.
	function automatic logic [31:0] word(input logic [1:0] b, input logic [11:0] r, input logic [8:0] c);
		return {9'h000, b, r, c};
	endfunction

	// Array answers one cycle late; monitors log outputs, skipping frozen suspend cycles.
	always @(posedge clock) begin
		array_rd_data <= word(array_rd_bank, array_rd_row, array_rd_col);
		if (!sys_rst && data_pins_oe_n !== 4'hF && power_state !== SDCBC_PW_SUSPEND) begin
			rq.push_back(data_pins_out);
		end
		if (!sys_rst && array_wr_valid === 1'b1 && array_wr_ready) begin
			wq.push_back(array_wr);
		end
		if (!sys_rst && refresh_pulse === 1'b1) begin
			nref++;
		end
	end

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Reads a four-word burst (or none when refused) and compares each word.
	task automatic rd_chk(input logic [1:0] b, input logic [11:0] r, input logic [8:0] c, input int k);
		rq.delete();
		ctl.send(SDCBC_CMD_RD, b, {3'h0, c});
		repeat (10) @(posedge clock);
		`CHK("read count", k, rq.size())
		for (int i = 0; i < k && i < rq.size(); i++) `CHK("read word", word(b, r, c + 9'(i)), rq[i])
	endtask

	// Writes a burst of four to bank two; with a stall the array refuses until the stall is checked, sixteen cycles after the command.
	task automatic wr_chk(input logic [8:0] c, input logic [3:0] m, input logic [31:0] d, input logic s);
		logic [31:0] keep;
		keep = {{8{~m[3]}}, {8{~m[2]}}, {8{~m[1]}}, {8{~m[0]}}};
		wq.delete();
		array_wr_ready <= !s;
		ctl.io(1'b1, m, d, 1'b1);
		ctl.send(SDCBC_CMD_WR, 2'h2, {3'h0, c});
		repeat (10) @(posedge clock);
		if (s) `CHK("write stall", 1'b1, wr_stall)
		array_wr_ready <= 1'b1;
		repeat (8) @(posedge clock);
		ctl.io(1'b1, 4'h0, d, 1'b0);
		`CHK("write count", 4, wq.size())
		foreach (wq[i]) `CHK("write slot", {2'h2, 12'h0AB, c + 9'(i), ~m, d & keep},
			{wq[i].bank, wq[i].row, wq[i].col, wq[i].byte_en, wq[i].data & keep})
	endtask

	// A hang counts as a mismatch and ends the run through the same verdict.
	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		summarize();
	end

	initial begin
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		`CHK("mode reset", SDCBC_MODE_RESET, mode_word)
		`CHK("pins released", 4'hF, data_pins_oe_n)
		ctl.send(4'hB, 2'h1, 12'h123);
		`CHK("deselect", 4'h0, bank_open)
		rd_chk(2'h1, 12'h123, 9'h010, 0);
		ctl.send(SDCBC_CMD_REF, 2'h0, 12'h000);
		`CHK("refresh", 1, nref)
		ctl.send(SDCBC_CMD_MODE, 2'h0, 12'h022);
		`CHK("mode load", 14'h0022, mode_word)
		ctl.send(SDCBC_CMD_ACT, 2'h1, 12'h123);
		ctl.send(SDCBC_CMD_ACT, 2'h2, 12'h0AB);
		`CHK("two open", 4'h6, bank_open)
		ctl.send(SDCBC_CMD_ACT, 2'h1, 12'h3C3);
		rd_chk(2'h1, 12'h123, 9'h010, 4);
		wr_chk(9'h020, 4'h0, 32'hA5A55A5A, 1'b0);
		wr_chk(9'h030, 4'h9, 32'h12345678, 1'b1);
		ctl.send(SDCBC_CMD_PRE, 2'h2, 12'h000);
		`CHK("close one", 4'h2, bank_open)
		ctl.send(SDCBC_CMD_PRE, 2'h0, 12'h400);
		`CHK("close all", 4'h0, bank_open)
		ctl.send(SDCBC_CMD_MODE, 2'h0, 12'h037);
		ctl.send(SDCBC_CMD_ACT, 2'h1, 12'h123);
		rq.delete();
		ctl.send(SDCBC_CMD_RD, 2'h1, 12'h5FF);
		repeat (5) @(posedge clock);
		for (int i = 0; i < 3; i++) `CHK("page wrap", word(2'h1, 12'h123, 9'h1FF + 9'(i)), rq[i])
		ctl.io(1'b0, 4'h0, 32'h0, 1'b0);
		repeat (6) @(posedge clock);
		`CHK("suspend", SDCBC_PW_SUSPEND, power_state)
		ctl.io(1'b1, 4'h0, 32'h0, 1'b0);
		// The gate must settle and the device wake before the stop, or the stop is lost.
		repeat (4) @(posedge clock);
		ctl.send(SDCBC_CMD_STOP, 2'h0, 12'h000);
		// Words still in the latency pipeline reach the monitor first.
		repeat (3) @(posedge clock);
		n = rq.size();
		repeat (10) @(posedge clock);
		`CHK("burst stopped", n, rq.size())
		`CHK("pins idle", 4'hF, data_pins_oe_n)
		`CHK("auto close", 4'h0, bank_open)
		ctl.io(1'b0, 4'h0, 32'h0, 1'b0);
		repeat (8) @(posedge clock);
		`CHK("power down", SDCBC_PW_DOWN, power_state)
		ctl.io(1'b1, 4'h0, 32'h0, 1'b0);
		repeat (8) @(posedge clock);
		`CHK("power up", SDCBC_PW_RUN, power_state)
		ctl.self_ref(1'b0);
		`CHK("self refresh", SDCBC_PW_SELF_REF, power_state)
		`CHK("no auto refresh", 1, nref)
		ctl.self_ref(1'b1);
		`CHK("self refresh exit", SDCBC_PW_RUN, power_state)
		summarize();
	end
endmodule
